// ===== rtl/boot_remap_regs.svh
`ifndef BOOT_REMAP_REGS_SVH
`define BOOT_REMAP_REGS_SVH

// ==================================================
// address map
`define VEC_END      32'h00000020
`define LOW_END      32'h00400000
`define PERI_BASE    32'hFFC00000
`define VIC_BASE     32'hFFFFF000
`define UI_BASE_W    18'h3FF80
`define UI_RCR       14'h0020
`define BANK_SHIFT   24
`define PWIN_SHIFT   14

// ==================================================
// bank config word and remap control fields
`define CSR_W16      0
`define CSR_WT_LO    2
`define CSR_WT_HI    4
`define CSR_FLT_LO   5
`define CSR_FLT_HI   7
`define CSR_BW       8
`define CSR_EARLY    9
`define CSR_EN       13
`define CSR_BA_LO    24
`define CSR_BA_HI    31
`define RCR_TRIG     0

// ==================================================
// reset values and access sizes
`define CSR0_RST     32'h01002000
`define CSRN_RST     32'h00000000
`define SZ_BYTE      2'h0
`define SZ_HALF      2'h1
`define SZ_WORD      2'h2
`define BOOT_SETTLE  2'h3

`endif

// ===== rtl/boot_remap_pkg.sv
package boot_remap_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INT,
    ST_FLT,
    ST_SETUP,
    ST_STROBE
  } st_t;

  typedef struct packed {
    logic [7:0] base;
    logic       en;
    logic       early;
    logic       bw;
    logic [2:0] flt;
    logic [2:0] wt;
    logic       w16;
  } bank_cfg_t;

endpackage

// ===== rtl/bank_cfg_if.sv
`timescale 1ns/1ps
interface bank_cfg_if;
  logic                      wr;
  logic [2:0]                widx;
  logic [31:0]               wdata;
  logic                      boot_cap;
  logic                      boot16;
  logic [7:0]                look;
  logic                      hit;
  logic [2:0]                hidx;
  boot_remap_pkg::bank_cfg_t hcfg;
  boot_remap_pkg::bank_cfg_t c0;
  logic [2:0]                ridx;
  logic [31:0]               rdata;

  modport store (input wr, widx, wdata, boot_cap, boot16, look, ridx,
                 output hit, hidx, hcfg, c0, rdata);
  modport user  (output wr, widx, wdata, boot_cap, boot16, look, ridx,
                 input hit, hidx, hcfg, c0, rdata);
endinterface

// ===== rtl/ebi_timer.sv
`timescale 1ns/1ps
module ebi_timer #(
  parameter int CW = 3
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          wait_ld,
  input  wire logic [CW-1:0] wait_n,
  input  wire logic          flt_ld,
  input  wire logic [CW-1:0] flt_n,
  output logic               wait_done,
  output logic               flt_busy
);
  logic [CW-1:0] wcnt_ff;
  logic [CW-1:0] fcnt_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wcnt_ff <= '0;
    end else if (wait_ld) begin
      wcnt_ff <= wait_n;
    end else if (wcnt_ff != '0) begin
      wcnt_ff <= wcnt_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fcnt_ff <= '0;
    end else if (flt_ld) begin
      fcnt_ff <= flt_n;
    end else if (fcnt_ff != '0) begin
      fcnt_ff <= fcnt_ff - 1'b1;
    end
  end

  assign wait_done = (wcnt_ff == '0);
  assign flt_busy  = (fcnt_ff != '0);
endmodule // ebi_timer

// ===== rtl/bank_config.sv
`timescale 1ns/1ps
`include "boot_remap_regs.svh"
module bank_config #(
  parameter int NB = 8
) (
  input wire logic   ref_clk,
  input wire logic   sys_rst,
  bank_cfg_if.store  cif
);
  boot_remap_pkg::bank_cfg_t cfg_all [NB];
  logic [NB-1:0]             match;

  function automatic boot_remap_pkg::bank_cfg_t unpack(input logic [31:0] w);
    boot_remap_pkg::bank_cfg_t c;
    c.base  = w[`CSR_BA_HI:`CSR_BA_LO];
    c.en    = w[`CSR_EN];
    c.early = w[`CSR_EARLY];
    c.bw    = w[`CSR_BW];
    c.flt   = w[`CSR_FLT_HI:`CSR_FLT_LO];
    c.wt    = w[`CSR_WT_HI:`CSR_WT_LO];
    c.w16   = w[`CSR_W16];
    return c;
  endfunction

  function automatic logic [31:0] pack(input boot_remap_pkg::bank_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[`CSR_BA_HI:`CSR_BA_LO]   = c.base;
    w[`CSR_EN]                 = c.en;
    w[`CSR_EARLY]              = c.early;
    w[`CSR_BW]                 = c.bw;
    w[`CSR_FLT_HI:`CSR_FLT_LO] = c.flt;
    w[`CSR_WT_HI:`CSR_WT_LO]   = c.wt;
    w[`CSR_W16]                = c.w16;
    return w;
  endfunction

  // ==================================================
  // one 16 MB bank per entry
  for (genvar g = 0; g < NB; g++) begin : g_bank
    boot_remap_pkg::bank_cfg_t cfg_ff;
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        cfg_ff <= unpack((g == 0) ? `CSR0_RST : `CSRN_RST);
      end else if (cif.wr && cif.widx == 3'(g)) begin
        cfg_ff <= unpack(cif.wdata);
      end else if (g == 0 && cif.boot_cap) begin
        cfg_ff.w16 <= cif.boot16; // RULE1
      end
    end
    assign cfg_all[g] = cfg_ff;
    assign match[g]   = cfg_ff.en && (cfg_ff.base == cif.look); // RULE9
  end

  always_comb begin
    cif.hit  = 1'b0;
    cif.hidx = 3'h0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (match[i]) begin
        cif.hit  = 1'b1;
        cif.hidx = 3'(i);
      end
    end
  end

  assign cif.hcfg  = cfg_all[cif.hidx];
  assign cif.c0    = cfg_all[0];
  assign cif.rdata = pack(cfg_all[cif.ridx]);

  boot_width_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    cif.boot_cap && !cif.wr |=> cfg_all[0].w16 == $past(cif.boot16))
    else $error("boot width not taken from strap");
endmodule // bank_config

// ===== rtl/boot_remap_address_decoder.sv
`timescale 1ns/1ps
`include "boot_remap_regs.svh"
// ==================================================
// Overview of operation
// (RULE1) strap sampled after reset: high gives 8-bit, low 16-bit boot bank zero
// (RULE2) vectors live at 0x0 to 0x20; remap picks boot memory or RAM there
// (RULE3) writing one to the remap trigger bit performs the remap
// (RULE4) chip selects one to seven work only after remap
// (RULE5) remap holds until system reset or external reset pin
// (RULE6) undefined address in external space raises abort
// (RULE7) internal memory and peripherals never abort
// (RULE8) addresses between 0x00400000 and 0xFFC00000 go to external bus unit
// (RULE9) eight banks, each 16 MB
// (RULE10) aligned byte, half-word and word accesses on every bank
// (RULE11) programmable wait states on every bank access
// (RULE12) programmable float time holds off next external cycle
// (RULE13) each bank is 8-bit or 16-bit wide
// (RULE14) 16-bit bank: byte-select or byte-write strobe mode
// (RULE15) optional early read strobe per bank
// (RULE16) peripheral accesses forced to aligned word
// (RULE17) 16 KB window per peripheral, 4 KB for interrupt controller
// (RULE18) control register: ones trigger, zeros do nothing
// (RULE19) before remap boot bank at vectors, after remap RAM there
module boot_remap_address_decoder #(
  parameter int NB = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        boot_width_select,
  input  wire logic        external_reset_pin_n,
  input  wire logic        cpu_req,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_we,
  input  wire logic [1:0]  cpu_size,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_ready,
  output logic             cpu_abort,
  output logic [31:0]      cpu_rdata,
  output logic             ram_sel,
  output logic             periph_sel,
  output logic [7:0]       periph_win,
  output logic             periph_vic,
  output logic [31:0]      tgt_addr,
  output logic             tgt_we,
  output logic [1:0]       tgt_size,
  output logic [31:0]      tgt_wdata,
  input  wire logic [31:0] ram_rdata,
  input  wire logic [31:0] periph_rdata,
  output logic [7:0]       ext_cs_n,
  output logic [23:0]      ext_addr,
  output logic             ext_rd_n,
  output logic [1:0]       ext_we_n,
  output logic [1:0]       ext_be_n,
  output logic [15:0]      ext_dout,
  output logic             ext_doe,
  input  wire logic [15:0] ext_din,
  output logic             remap_done
);
  boot_remap_pkg::st_t       st_ff;
  boot_remap_pkg::st_t       nxt_st;
  boot_remap_pkg::bank_cfg_t cfg_ff;
  boot_remap_pkg::bank_cfg_t sel_cfg;
  logic        bws_m_ff, bws_s_ff, erst_m_ff, erst_s_ff;
  logic [1:0]  settle_ff;
  logic        remap_ff;
  logic        cpu_ready_ff, cpu_abort_ff;
  logic [31:0] rdata_ff;
  logic        ram_sel_ff, periph_sel_ff, vic_ff, tgt_we_ff;
  logic [7:0]  win_ff;
  logic [31:0] tgt_addr_ff, tgt_wdata_ff;
  logic [1:0]  tgt_size_ff;
  logic [2:0]  bank_ff;
  logic [21:0] xaddr_ff;
  logic [1:0]  off_ff, beats_ff, size_ff;
  logic        we_ff;
  logic [31:0] wdata_ff;
  logic [7:0]  cs_n_ff;
  logic        rd_n_ff, doe_ff;
  logic [1:0]  we_n_ff;
  logic        take, take_int, take_ext, take_now, abort_now;
  logic        in_low, in_peri, in_ext, in_ui, ui_reg, rcr_wr, ext_ok;
  logic [13:0] ui_off;
  logic [2:0]  sel_idx;
  logic [1:0]  a_off, n_beats, ln, step;
  logic        wait_done, flt_busy, last;

  bank_cfg_if cif ();

  // ==================================================
  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bws_m_ff  <= 1'b0;
      bws_s_ff  <= 1'b0;
      erst_m_ff <= 1'b1;
      erst_s_ff <= 1'b1;
    end else begin
      bws_m_ff  <= boot_width_select;
      bws_s_ff  <= bws_m_ff;
      erst_m_ff <= external_reset_pin_n;
      erst_s_ff <= erst_m_ff;
    end
  end

  // strap is read only once the synchroniser has flushed its reset value
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !erst_s_ff) begin
      settle_ff <= `BOOT_SETTLE;
    end else if (settle_ff != 2'h0) begin
      settle_ff <= settle_ff - 2'h1;
    end
  end

  // ==================================================
  // address decode
  assign take    = cpu_req && !cpu_ready_ff && (st_ff == boot_remap_pkg::ST_IDLE);
  assign in_low  = cpu_addr < `LOW_END;
  assign in_peri = cpu_addr >= `PERI_BASE;
  assign in_ext  = !in_low && !in_peri; // RULE8
  assign in_ui   = cpu_addr[31:14] == `UI_BASE_W;
  assign ui_off  = {cpu_addr[13:2], 2'b00}; // RULE16
  assign ui_reg  = ui_off < `UI_RCR;
  assign rcr_wr  = take && in_ui && cpu_we && (ui_off == `UI_RCR);
  assign sel_cfg = in_low ? cif.c0 : cif.hcfg;
  assign sel_idx = in_low ? 3'h0 : cif.hidx;
  // low area is boot bank before remap, RAM after
  assign ext_ok  = in_low ? !remap_ff // RULE2 RULE19
                 : (in_ext && cif.hit && (remap_ff || cif.hidx == 3'h0)); // RULE4

  assign take_int  = take && ((in_low && remap_ff) || (in_peri && !in_ui));
  assign take_ext  = take && !in_peri && ext_ok;
  assign take_now  = take && !take_int && !take_ext;
  assign abort_now = take && in_ext && !ext_ok; // RULE6

  always_comb begin
    case (cpu_size) // RULE10
      `SZ_BYTE: a_off = cpu_addr[1:0];
      `SZ_HALF: a_off = {cpu_addr[1], 1'b0};
      default:  a_off = 2'b00;
    endcase
    if (sel_cfg.w16) begin
      n_beats = (cpu_size == `SZ_WORD) ? 2'h1 : 2'h0; // RULE13
    end else begin
      case (cpu_size)
        `SZ_BYTE: n_beats = 2'h0;
        `SZ_HALF: n_beats = 2'h1;
        default:  n_beats = 2'h3;
      endcase
    end
  end

  assign cif.wr       = take && in_ui && cpu_we && ui_reg;
  assign cif.widx     = ui_off[4:2];
  assign cif.wdata    = cpu_wdata;
  assign cif.look     = cpu_addr[31:`BANK_SHIFT];
  assign cif.ridx     = ui_off[4:2];
  assign cif.boot_cap = settle_ff == 2'h1;
  assign cif.boot16   = !bws_s_ff; // RULE1

  bank_config #(
    .NB (NB)
  ) u_cfg (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cif     (cif.store)
  );

  // ==================================================
  // remap state
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !erst_s_ff) begin
      remap_ff <= 1'b0; // RULE5
    end else if (rcr_wr && cpu_wdata[`RCR_TRIG]) begin
      remap_ff <= 1'b1; // RULE3 RULE18
    end
  end

  // ==================================================
  // sequencer
  assign last = (st_ff == boot_remap_pkg::ST_STROBE) && wait_done && (beats_ff == 2'h0);

  always_comb begin
    case (st_ff)
      boot_remap_pkg::ST_IDLE: begin
        if (take_int) begin
          nxt_st = boot_remap_pkg::ST_INT;
        end else if (take_ext) begin
          nxt_st = boot_remap_pkg::ST_FLT;
        end else begin
          nxt_st = boot_remap_pkg::ST_IDLE;
        end
      end
      boot_remap_pkg::ST_FLT: begin
        nxt_st = flt_busy ? boot_remap_pkg::ST_FLT : boot_remap_pkg::ST_SETUP; // RULE12
      end
      boot_remap_pkg::ST_SETUP: nxt_st = boot_remap_pkg::ST_STROBE;
      boot_remap_pkg::ST_STROBE: begin
        if (!wait_done) begin
          nxt_st = boot_remap_pkg::ST_STROBE; // RULE11
        end else if (beats_ff != 2'h0) begin
          nxt_st = boot_remap_pkg::ST_SETUP;
        end else begin
          nxt_st = boot_remap_pkg::ST_IDLE;
        end
      end
      default: nxt_st = boot_remap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= boot_remap_pkg::ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ebi_timer #(
    .CW (3)
  ) u_tmr (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .wait_ld   (st_ff == boot_remap_pkg::ST_SETUP),
    .wait_n    (cfg_ff.wt),
    .flt_ld    (last),
    .flt_n     (cfg_ff.flt),
    .wait_done (wait_done),
    .flt_busy  (flt_busy)
  );

  // ==================================================
  // external beat state
  assign step = cfg_ff.w16 ? 2'h2 : 2'h1;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_ff   <= '0;
      bank_ff  <= 3'h0;
      xaddr_ff <= '0;
      off_ff   <= 2'h0;
      beats_ff <= 2'h0;
      size_ff  <= `SZ_BYTE;
      we_ff    <= 1'b0;
      wdata_ff <= '0;
    end else if (take_ext) begin
      cfg_ff   <= sel_cfg;
      bank_ff  <= sel_idx;
      xaddr_ff <= cpu_addr[23:2];
      off_ff   <= a_off;
      beats_ff <= n_beats;
      size_ff  <= cpu_size;
      we_ff    <= cpu_we;
      wdata_ff <= cpu_wdata;
    end else if (st_ff == boot_remap_pkg::ST_STROBE && wait_done && beats_ff != 2'h0) begin
      off_ff   <= off_ff + step;
      beats_ff <= beats_ff - 2'h1;
    end
  end

  // byte lanes of the current beat
  always_comb begin
    if (!cfg_ff.w16) begin
      ln = 2'b01;
    end else if (size_ff == `SZ_BYTE) begin
      ln = off_ff[0] ? 2'b10 : 2'b01;
    end else begin
      ln = 2'b11;
    end
  end

  // ==================================================
  // external pins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cs_n_ff <= 8'hFF;
      rd_n_ff <= 1'b1;
      we_n_ff <= 2'b11;
      doe_ff  <= 1'b0;
    end else if (nxt_st == boot_remap_pkg::ST_SETUP) begin
      cs_n_ff <= ~(8'h01 << bank_ff);
      rd_n_ff <= !(cfg_ff.early && !we_ff); // RULE15
      we_n_ff <= 2'b11;
      doe_ff  <= we_ff;
    end else if (st_ff == boot_remap_pkg::ST_SETUP) begin
      rd_n_ff <= we_ff;
      // byte-write drives one strobe per 8-bit device
      we_n_ff <= !we_ff ? 2'b11 : (cfg_ff.bw ? ~ln : 2'b10); // RULE14
    end else if (last) begin
      cs_n_ff <= 8'hFF;
      rd_n_ff <= 1'b1;
      we_n_ff <= 2'b11;
      doe_ff  <= 1'b0;
    end
  end

  assign ext_cs_n = cs_n_ff;
  assign ext_rd_n = rd_n_ff;
  assign ext_we_n = we_n_ff;
  assign ext_doe  = doe_ff;
  assign ext_addr = {xaddr_ff, off_ff};
  // byte-select mode marks lanes; byte-write leaves them active
  assign ext_be_n = (cs_n_ff == 8'hFF) ? 2'b11 : (cfg_ff.bw ? 2'b00 : ~ln); // RULE14
  assign ext_dout = cfg_ff.w16 ? wdata_ff[{off_ff[1], 4'h0} +: 16]
                  : {8'h00, wdata_ff[{off_ff, 3'h0} +: 8]};

  // ==================================================
  // internal targets
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ram_sel_ff    <= 1'b0;
      periph_sel_ff <= 1'b0;
      tgt_addr_ff   <= '0;
      tgt_size_ff   <= `SZ_BYTE;
      tgt_we_ff     <= 1'b0;
      tgt_wdata_ff  <= '0;
      win_ff        <= 8'h00;
      vic_ff        <= 1'b0;
    end else begin
      ram_sel_ff    <= take_int && in_low;
      periph_sel_ff <= take_int && in_peri;
      if (take_int) begin
        tgt_addr_ff  <= in_peri ? {cpu_addr[31:2], 2'b00} : cpu_addr; // RULE16
        tgt_size_ff  <= in_peri ? `SZ_WORD : cpu_size;
        tgt_we_ff    <= cpu_we;
        tgt_wdata_ff <= cpu_wdata;
        win_ff       <= cpu_addr[21:`PWIN_SHIFT]; // RULE17
        vic_ff       <= cpu_addr >= `VIC_BASE;
      end
    end
  end

  assign ram_sel    = ram_sel_ff;
  assign periph_sel = periph_sel_ff;
  assign tgt_addr   = tgt_addr_ff;
  assign tgt_size   = tgt_size_ff;
  assign tgt_we     = tgt_we_ff;
  assign tgt_wdata  = tgt_wdata_ff;
  assign periph_win = win_ff;
  assign periph_vic = vic_ff;

  // ==================================================
  // processor answer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cpu_ready_ff <= 1'b0;
      cpu_abort_ff <= 1'b0;
    end else begin
      cpu_ready_ff <= take_now || (st_ff == boot_remap_pkg::ST_INT) || last;
      cpu_abort_ff <= abort_now; // RULE6 RULE7
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (take_now) begin
      // control register is write-only and reads zero
      rdata_ff <= (in_ui && ui_reg && !cpu_we) ? cif.rdata : 32'h00000000; // RULE18
    end else if (take_ext) begin
      rdata_ff <= '0;
    end else if (st_ff == boot_remap_pkg::ST_INT) begin
      rdata_ff <= ram_sel_ff ? ram_rdata : periph_rdata;
    end else if (st_ff == boot_remap_pkg::ST_STROBE && wait_done && !we_ff) begin
      if (cfg_ff.w16 && size_ff != `SZ_BYTE) begin
        rdata_ff[{off_ff[1], 4'h0} +: 16] <= ext_din;
      end else begin
        rdata_ff[{off_ff, 3'h0} +: 8] <= (cfg_ff.w16 && off_ff[0]) ? ext_din[15:8] : ext_din[7:0];
      end
    end
  end

  assign cpu_ready  = cpu_ready_ff;
  assign cpu_abort  = cpu_abort_ff;
  assign cpu_rdata  = rdata_ff;
  assign remap_done = remap_ff;

  // ==================================================
  // checks
  vec_to_ram_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    take && remap_ff && cpu_addr < `VEC_END |=> ram_sel_ff && !cpu_abort_ff)
    else $error("vector access after remap missed RAM");

  vec_to_boot_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE19
    take && !remap_ff && cpu_addr < `VEC_END
    |=> st_ff == boot_remap_pkg::ST_FLT && bank_ff == 3'h0 && !ram_sel_ff)
    else $error("vector access before remap missed boot bank");

  remap_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
    rcr_wr && cpu_wdata[`RCR_TRIG] && erst_s_ff |=> remap_ff ##1 remap_done)
    else $error("remap trigger ignored");

  remap_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
    remap_ff && erst_s_ff |=> remap_ff)
    else $error("remap lost without reset");

  cs_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
    !remap_ff && !$past(remap_ff) |-> ext_cs_n[7:1] == 7'h7F)
    else $error("upper chip select before remap");

  undef_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
    take && in_ext && !cif.hit |=> cpu_ready && cpu_abort)
    else $error("undefined external address not aborted");

  int_no_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
    take && (in_peri || (in_low && remap_ff)) |=> !cpu_abort ##1 !cpu_abort)
    else $error("abort on internal access");

  wait_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE11
    st_ff == boot_remap_pkg::ST_SETUP && cfg_ff.wt == 3'h2
    |=> (st_ff == boot_remap_pkg::ST_STROBE) [*3])
    else $error("wait states not inserted");

  float_gap_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE12
    last && cfg_ff.flt == 3'h1 |=> flt_busy ##1 !flt_busy)
    else $error("float time not honoured");

  early_rd_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE15
    st_ff == boot_remap_pkg::ST_SETUP && !we_ff |-> ext_rd_n == !cfg_ff.early)
    else $error("early read strobe wrong");

  periph_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE16
    take && in_peri && !in_ui |=> periph_sel && tgt_addr[1:0] == 2'b00 && tgt_size == `SZ_WORD)
    else $error("peripheral access not forced to word");
endmodule // boot_remap_address_decoder

// ===== sim/ext_mem_model.sv
`timescale 1ns/1ps
// ==================================================
// external memory: each lane returns a byte derived from its beat address
module ext_mem_model (
  input  wire logic [7:0]  ext_cs_n,
  input  wire logic [23:0] ext_addr,
  input  wire logic        ext_rd_n,
  output logic [15:0]      ext_din
);
  logic [15:0] pattern;

  assign pattern = {~ext_addr[7:0], ext_addr[7:0]};

  // released or unselected bus shows the inverse so a stale sample cannot pass
  always_comb begin
    if (!(&ext_cs_n) && !ext_rd_n) begin
      ext_din = pattern;
    end else begin
      ext_din = ~pattern;
    end
  end
endmodule // ext_mem_model

// ===== sim/boot_remap_address_decoder_tb.sv
`timescale 1ns/1ps
module boot_remap_address_decoder_tb;
  logic        ref_clk, sys_rst, boot_width_select, external_reset_pin_n;
  logic        cpu_req, cpu_we, cpu_ready, cpu_abort, ram_sel, periph_sel;
  logic        periph_vic, tgt_we, ext_rd_n, ext_doe, remap_done, ab;
  logic [1:0]  cpu_size, tgt_size, ext_we_n, ext_be_n;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, tgt_addr, tgt_wdata, ram_rdata, periph_rdata;
  logic [7:0]  periph_win, ext_cs_n;
  logic [23:0] ext_addr;
  logic [15:0] ext_dout, ext_din;
  int          n_errors, n_tests, cyc, lat, n_ram, n_per;
  logic [12:0] pins;
  logic [15:0] wdout;
  logic [23:0] waddr;

  boot_remap_address_decoder #(.NB(8)) dut (.ref_clk, .sys_rst, .boot_width_select,
    .external_reset_pin_n, .cpu_req, .cpu_addr, .cpu_we, .cpu_size, .cpu_wdata, .cpu_ready,
    .cpu_abort, .cpu_rdata, .ram_sel, .periph_sel, .periph_win, .periph_vic, .tgt_addr,
    .tgt_we, .tgt_size, .tgt_wdata, .ram_rdata, .periph_rdata, .ext_cs_n, .ext_addr,
    .ext_rd_n, .ext_we_n, .ext_be_n, .ext_dout, .ext_doe, .ext_din, .remap_done);

  ext_mem_model mem (.ext_cs_n, .ext_addr, .ext_rd_n, .ext_din);

  // ==================================================
  // clock, timeout, helpers
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (ram_sel === 1'b1) n_ram++;
    if (periph_sel === 1'b1) n_per++;
    // pins seen while a write strobe is low
    if (ext_we_n !== 2'b11) begin
      pins  = {ext_cs_n, ext_be_n, ext_we_n, ext_doe};
      wdout = ext_dout;
      waddr = ext_addr;
    end
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until ready, dropped on the edge after it
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    cpu_req   <= 1'b1;
    cpu_addr  <= a;
    cpu_we    <= w;
    cpu_size  <= s;
    cpu_wdata <= d;
    lat = 0;
    do begin
      @(posedge ref_clk);
      #1;
      lat++;
    end while (cpu_ready !== 1'b1 && lat < 60);
    ab = cpu_abort;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
  endtask

  task automatic pin_reset(input logic strap);
    boot_width_select    <= strap;
    external_reset_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    external_reset_pin_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask

  // ==================================================
  // scenarios
  task automatic t_boot(input logic [31:0] exp_d, input int exp_lat);
    int r0;
    r0 = n_ram;
    acc(32'h00000000, 1'b0, 2'h2, 32'h00000000);
    chk("boot data", cpu_rdata, exp_d);
    chk("boot latency", lat, exp_lat);
    chk("boot abort", ab, 1'b0);
    chk("boot ram", n_ram - r0, 0);
  endtask

  task automatic t_pre_remap();
    // bank1: base 0x02, 16-bit, 2 waits, 1 float, early read on
    acc(32'hFFE00004, 1'b1, 2'h2, 32'h02002229);
    chk("cfg latency", lat, 1);
    acc(32'h02000000, 1'b0, 2'h2, 32'h00000000);
    chk("bank1 early abort", ab, 1'b1);
    chk("bank1 early latency", lat, 1);
    acc(32'h80000000, 1'b0, 2'h1, 32'h00000000);
    chk("undefined abort", ab, 1'b1);
    acc(32'hFFE00020, 1'b1, 2'h2, 32'h00000000);
    chk("zero trigger", remap_done, 1'b0);
  endtask

  task automatic t_remap();
    acc(32'hFFE00020, 1'b1, 2'h2, 32'h00000001);
    chk("remap state", remap_done, 1'b1);
    acc(32'hFFE00020, 1'b1, 2'h2, 32'h00000000);
    chk("remap kept", remap_done, 1'b1);
    acc(32'h00000010, 1'b0, 2'h2, 32'h00000000);
    chk("ram data", cpu_rdata, ram_rdata);
    chk("ram latency", lat, 2);
    chk("ram abort", ab, 1'b0);
    chk("ram addr", tgt_addr, 32'h00000010);
    acc(32'h02000000, 1'b0, 2'h2, 32'h00000000);
    chk("bank1 data", cpu_rdata, 32'hFD02FF00);
    chk("bank1 latency", lat, 10);
    chk("bank1 abort", ab, 1'b0);
    acc(32'h02000001, 1'b1, 2'h0, 32'h0000AB00);
    chk("bank1 wr pins", pins, {8'hFD, 2'h1, 2'h2, 1'b1});
    chk("bank1 wr data", wdout, 16'hAB00);
    chk("bank1 wr addr", waddr, 24'h000001);
    chk("bank1 wr abort", ab, 1'b0);
  endtask

  task automatic t_periph();
    int p0;
    p0 = n_per;
    acc(32'hFFFC4003, 1'b0, 2'h0, 32'h00000000);
    chk("periph addr", tgt_addr, 32'hFFFC4000);
    chk("periph size", tgt_size, 2'h2);
    chk("periph window", periph_win, 8'hF1);
    chk("periph vic low", periph_vic, 1'b0);
    chk("periph abort", ab, 1'b0);
    chk("periph data", cpu_rdata, periph_rdata);
    acc(32'hFFFFF106, 1'b1, 2'h1, 32'h00AB0000);
    chk("vic select", periph_vic, 1'b1);
    chk("vic addr", tgt_addr, 32'hFFFFF104);
    chk("vic we", tgt_we, 1'b1);
    chk("vic wdata", tgt_wdata, 32'h00AB0000);
    chk("periph sel count", n_per - p0, 2);
  endtask

  // ==================================================
  // main sequence
  initial begin
    sys_rst              = 1'b1;
    boot_width_select    = 1'b1;
    external_reset_pin_n = 1'b1;
    cpu_req              = 1'b0;
    cpu_addr             = 32'h00000000;
    cpu_we               = 1'b0;
    cpu_size             = 2'h2;
    cpu_wdata            = 32'h00000000;
    ram_rdata            = 32'hC3A55A3C;
    periph_rdata         = 32'h12345678;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    t_boot(32'h03020100, 10);
    t_pre_remap();
    t_remap();
    t_periph();
    pin_reset(1'b0);
    chk("pin clears remap", remap_done, 1'b0);
    t_boot(32'hFD02FF00, 6);
    report_and_stop();
  end
endmodule // boot_remap_address_decoder_tb
